// [design/ccmr_top.sv]
// Channel and type mapper with lane rate control and I2C registers
// Function
// RULE1 - VC in two MSBs, type in six LSBs
// RULE2 - CSI-2 input keeps the received type
// RULE3 - Raw input gets the port's configured identifier
// RULE4 - Raw framing taken from FV and LV
// RULE5 - Parallel source supplies discrete sync signals
// RULE6 - Raw 8, 10 and 12 bit accepted
// RULE7 - Raw10 identifier 0x70, raw12 at 0x71
// RULE8 - Identifier bits 7:6 VC, 5:0 type
// RULE9 - Two-bit VC, four channels interleaved
// RULE10 - Per-port VC remap through register 0x72
// RULE11 - Both ports merged into one output
// RULE12 - Rate field at 0x1F, 01 reserved
// RULE13 - Lane rate scales with reference clock
// RULE14 - Lane timing automatic at 800 and 1600
// RULE15 - Host writes timing and override otherwise
// RULE16 - Internal timing scales with reference frequency
// RULE17 - 400 rate: PLL automatic, timing from host
// RULE18 - Host writes 400 rate timing via 0xB2
// RULE19 - Header is identifier, word count, ECC
// RULE20 - Types 0x00 to 0x0F are short packets
// RULE21 - Remap before interleave, type untouched
// RULE22 - Remap register holds four 2-bit fields
`timescale 1ns/1ps
module ccmr_top import ccmr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h3D // Arbitrary bus address
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic [4:0] REF_MHZ,
  input wire logic [1:0] RX_PKT_VLD,
  input wire logic [1:0][1:0] RX_VC,
  input wire logic [1:0][5:0] RX_DT,
  input wire logic [1:0][15:0] RX_WC,
  input wire logic [1:0] RX_FV,
  input wire logic [1:0] RX_LV,
  input wire logic [1:0] RX_PIX_VLD,
  output logic TX_VLD,
  output logic [7:0] TX_DI,
  output logic [15:0] TX_WC,
  output logic TX_SHORT,
  output logic [11:0] LANE_RATE_MBPS,
  output logic [1:0] PLL_RATE_SEL,
  output logic [7:0] HS_TIMING,
  output logic TIMING_OVR
);
  // Serial slave states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACKA = 8'h04,
    ST_REG = 8'h08,
    ST_ACKW = 8'h10,
    ST_WDATA = 8'h20,
    ST_RDATA = 8'h40,
    ST_RACK = 8'h80
  } ccmr_i2c_type;

  // Whole state of the register clock domain
  typedef struct packed {
    logic scl1, scl2, scl3; // Clock line sync and history
    logic sda1, sda2, sda3; // Data line sync and history
    ccmr_i2c_type st; // Slave state
    logic [3:0] bitc; // Bit counter
    logic [7:0] sh; // Shift register
    logic rw; // Read transfer
    logic [7:0] ptr; // Register pointer
    logic oe_n; // Data line enable
    logic sda_o; // Data line level
    logic [7:0] rate; // Rate register
    logic [7:0] hs; // Written lane timing
    logic psel; // Port select
    ccmr_cfg_type regs; // Per-port registers
    ccmr_cfg_type sent; // Word on the crossing
    logic req_t, ack1, ack2; // Crossing handshake
    logic [4:0] ref1, ref2; // Reference strap sync
    logic [11:0] lane; // Lane rate output
    logic [7:0] hs_out; // Timing output
    logic [1:0] pll; // PLL rate output
    logic ovr; // Override output
  } ccmr_mst_type;

  // Whole state of the link clock domain outside u_sync
  typedef struct packed {
    logic [1:0] fv, lv; // Sync history
    logic [1:0][15:0] pix; // Pixel counts
    logic [1:0] pend; // Header waiting
    logic [1:0] psh; // Waiting header is short
    logic [1:0][7:0] pdi; // Waiting identifier
    logic [1:0][15:0] pwc; // Waiting word count
    logic rr; // Port favoured next
    logic vld; // Output valid
    logic [7:0] di; // Output identifier
    logic [15:0] wc; // Output word count
    logic sh; // Output is short
  } ccmr_lnk_type;

  ccmr_mst_type q_m;
  ccmr_mst_type d_m;
  ccmr_lnk_type q_l;
  ccmr_lnk_type d_l;
  ccmr_cfg_type pc; // Link-side configuration
  logic lnk_rst; // Link-side reset
  ccmr_cfg_if cfg_if();

  // Output channel for an input channel
  function automatic logic [1:0] remap_vc(input logic [7:0] map,
                                          input logic [1:0] vc);
    return map[{vc, 1'b0} +: 2]; // [RULE22]
  endfunction

  // Byte count of a raw line from its pixel count
  function automatic logic [15:0] raw_wc(input ccmr_mode_type m,
                                         input logic [15:0] px);
    case (m)
      MODE_RAW10: return px + {2'h0, px[15:2]};
      MODE_RAW12: return px + {1'h0, px[15:1]};
      default: return px;
    endcase // [RULE6]
  endfunction

  // Identifier register that applies to a raw port
  function automatic logic [7:0] raw_di(input ccmr_pcfg_type c);
    return (c.mode == MODE_RAW12) ? c.raw12 : c.raw10; // [RULE7]
  endfunction

  // Register read mux
  function automatic logic [7:0] rd_reg(input ccmr_mst_type s);
    case (s.ptr)
      REG_RATE: return s.rate;
      REG_LANE_STS: return s.lane[11:4];
      REG_PORT_SEL: return {7'h00, s.psel};
      REG_PORT_MODE: return {6'h00, s.regs[s.psel].mode};
      REG_RAW10: return s.regs[s.psel].raw10;
      REG_RAW12: return s.regs[s.psel].raw12;
      REG_REMAP: return s.regs[s.psel].remap;
      REG_HS_TIMING: return s.hs;
      default: return 8'h00;
    endcase
  endfunction

  // Register domain next state
  always_comb begin
    logic rise, fall, start, stop;
    logic [7:0] rdv;
    d_m = q_m;
    rise = ~q_m.scl3 & q_m.scl2;
    fall = q_m.scl3 & ~q_m.scl2;
    start = q_m.scl3 & q_m.scl2 & q_m.sda3 & ~q_m.sda2;
    stop = q_m.scl3 & q_m.scl2 & ~q_m.sda3 & q_m.sda2;
    rdv = rd_reg(q_m);
    d_m.scl1 = SCL_IN;
    d_m.scl2 = q_m.scl1;
    d_m.scl3 = q_m.scl2;
    d_m.sda1 = SDA_IN;
    d_m.sda2 = q_m.sda1;
    d_m.sda3 = q_m.sda2;
    d_m.sda_o = 1'b0;
    // Shift in on rising clock in receive states
    if (rise && (q_m.st == ST_ADDR || q_m.st == ST_REG ||
                 q_m.st == ST_WDATA)) begin
      d_m.sh = {q_m.sh[6:0], q_m.sda2};
      d_m.bitc = q_m.bitc + 4'h1;
    end
    case (q_m.st)
      ST_ADDR: if (fall && q_m.bitc == 4'h8) begin
        if (q_m.sh[7:1] == DEV_ADDR) begin
          d_m.rw = q_m.sh[0];
          d_m.oe_n = 1'b0;
          d_m.st = ST_ACKA;
        end else begin
          d_m.st = ST_IDLE;
        end
      end
      ST_ACKA: if (fall) begin
        d_m.bitc = 4'h0;
        if (q_m.rw) begin
          d_m.oe_n = rdv[7];
          d_m.sh = {rdv[6:0], 1'b1};
          d_m.st = ST_RDATA;
        end else begin
          d_m.oe_n = 1'b1;
          d_m.st = ST_REG;
        end
      end
      ST_REG: if (fall && q_m.bitc == 4'h8) begin
        d_m.ptr = q_m.sh;
        d_m.oe_n = 1'b0;
        d_m.st = ST_ACKW;
      end
      ST_ACKW: if (fall) begin
        d_m.oe_n = 1'b1;
        d_m.bitc = 4'h0;
        d_m.st = ST_WDATA;
      end
      ST_WDATA: if (fall && q_m.bitc == 4'h8) begin
        // Register write, pointer auto-increments
        case (q_m.ptr)
          REG_RATE: begin
            if (q_m.sh[1:0] != RATE_RSVD) begin
              d_m.rate[1:0] = q_m.sh[1:0]; // [RULE12]
            end
            d_m.rate[RATE_OVR_BIT] = q_m.sh[RATE_OVR_BIT];
          end
          REG_PORT_SEL: d_m.psel = q_m.sh[0];
          REG_PORT_MODE:
            d_m.regs[q_m.psel].mode = ccmr_mode_type'(q_m.sh[1:0]);
          REG_RAW10: d_m.regs[q_m.psel].raw10 = q_m.sh; // [RULE7]
          REG_RAW12: d_m.regs[q_m.psel].raw12 = q_m.sh; // [RULE7]
          REG_REMAP: d_m.regs[q_m.psel].remap = q_m.sh; // [RULE10]
          REG_HS_TIMING: d_m.hs = q_m.sh;
          default: ;
        endcase
        d_m.ptr = q_m.ptr + 8'h01;
        d_m.oe_n = 1'b0;
        d_m.st = ST_ACKW;
      end
      ST_RDATA: begin
        if (rise) begin
          d_m.bitc = q_m.bitc + 4'h1;
        end
        if (fall && q_m.bitc == 4'h8) begin
          d_m.oe_n = 1'b1;
          d_m.st = ST_RACK;
        end else if (fall) begin
          d_m.oe_n = q_m.sh[7];
          d_m.sh = {q_m.sh[6:0], 1'b1};
        end
      end
      ST_RACK: begin
        // Master acknowledge continues the read, else stop
        if (rise && q_m.sda2) begin
          d_m.st = ST_IDLE;
        end else if (rise) begin
          d_m.ptr = q_m.ptr + 8'h01;
        end else if (fall) begin
          d_m.bitc = 4'h0;
          d_m.oe_n = rdv[7];
          d_m.sh = {rdv[6:0], 1'b1};
          d_m.st = ST_RDATA;
        end
      end
      default: ;
    endcase
    // Start and stop override any state
    if (start) begin
      d_m.st = ST_ADDR;
      d_m.bitc = 4'h0;
      d_m.oe_n = 1'b1;
    end else if (stop) begin
      d_m.st = ST_IDLE;
      d_m.oe_n = 1'b1;
    end
    // Send a changed configuration once the last one is taken
    d_m.ack1 = cfg_if.ack_t;
    d_m.ack2 = q_m.ack1;
    if (q_m.ack2 == q_m.req_t && q_m.regs != q_m.sent) begin
      d_m.sent = q_m.regs;
      d_m.req_t = ~q_m.req_t;
    end
    // Lane rate follows the reference frequency
    d_m.ref1 = REF_MHZ;
    d_m.ref2 = q_m.ref1;
    case (q_m.rate[1:0])
      RATE_1600: d_m.lane = {1'h0, q_m.ref2, 6'h00}; // [RULE13] [RULE16]
      RATE_800: d_m.lane = {2'h0, q_m.ref2, 5'h00}; // [RULE13]
      default: d_m.lane = {3'h0, q_m.ref2, 4'h0}; // [RULE13]
    endcase
    // Automatic timing unless overridden or at the slow rate
    if (q_m.rate[1:0] == RATE_1600 && !q_m.rate[RATE_OVR_BIT]) begin
      d_m.hs_out = HS_AUTO_1600; // [RULE14]
    end else if (q_m.rate[1:0] == RATE_800 &&
                 !q_m.rate[RATE_OVR_BIT]) begin
      d_m.hs_out = HS_AUTO_800; // [RULE14]
    end else begin
      d_m.hs_out = q_m.hs; // [RULE17]
    end
    d_m.pll = q_m.rate[1:0]; // [RULE17]
    d_m.ovr = q_m.rate[RATE_OVR_BIT];
    if (SYS_RST) begin
      d_m = '0;
      // Line syncs start at the idle high level, so no false edge follows
      d_m.scl1 = 1'b1;
      d_m.scl2 = 1'b1;
      d_m.scl3 = 1'b1;
      d_m.sda1 = 1'b1;
      d_m.sda2 = 1'b1;
      d_m.sda3 = 1'b1;
      d_m.st = ST_IDLE;
      d_m.oe_n = 1'b1;
      d_m.rate = RATE_RST;
      d_m.hs = HS_RST;
      d_m.regs = {2{PCFG_RST}};
      d_m.sent = {2{PCFG_RST}};
      d_m.hs_out = HS_AUTO_1600;
    end
  end

  // Register domain state
  always_ff @(posedge MCLK) begin
    q_m <= d_m;
  end

  assign cfg_if.data = q_m.sent;
  assign cfg_if.req_t = q_m.req_t;

  // Configuration crossing into the link domain
  ccmr_cfg_sync u_sync (
    .link_clk(LINK_CLK),
    .sys_rst(SYS_RST),
    .cfg_if(cfg_if),
    .cfg(pc),
    .link_rst(lnk_rst)
  );

  // Link domain next state: framing, remap and interleave
  always_comb begin
    logic ev, esh, g;
    logic [7:0] edi;
    logic [15:0] ewc;
    d_l = q_l;
    ev = 1'b0;
    esh = 1'b1;
    g = 1'b0;
    edi = 8'h00;
    ewc = 16'h0000;
    d_l.fv = RX_FV;
    d_l.lv = RX_LV;
    d_l.vld = 1'b0;
    // Round-robin grant of one waiting header per cycle
    if (q_l.pend != 2'b00) begin
      g = (q_l.pend == 2'b11) ? q_l.rr : q_l.pend[1]; // [RULE9] [RULE11]
      d_l.vld = 1'b1;
      d_l.di = q_l.pdi[g];
      d_l.wc = q_l.pwc[g]; // [RULE19]
      d_l.sh = q_l.psh[g];
      d_l.pend[g] = 1'b0;
      d_l.rr = ~g;
    end
    for (int p = 0; p < 2; p++) begin
      ev = 1'b0;
      esh = 1'b1;
      edi = 8'h00;
      ewc = 16'h0000;
      if (pc[p].mode == MODE_CSI2) begin
        if (RX_PKT_VLD[p]) begin
          ev = 1'b1;
          edi = {remap_vc(pc[p].remap, RX_VC[p]), RX_DT[p]}; // [RULE21]
          ewc = RX_WC[p]; // [RULE2]
          esh = RX_DT[p] <= DT_SHORT_MAX; // [RULE20]
        end
      end else begin
        // Discrete sync levels frame the raw stream
        if (RX_LV[p] && !q_l.lv[p]) begin
          d_l.pix[p] = 16'h0000; // [RULE5]
        end else if (RX_LV[p] && RX_PIX_VLD[p]) begin
          d_l.pix[p] = q_l.pix[p] + 16'h0001;
        end
        if (!RX_LV[p] && q_l.lv[p]) begin
          ev = 1'b1;
          edi = raw_di(pc[p]); // [RULE3] [RULE8]
          ewc = raw_wc(pc[p].mode, q_l.pix[p]); // [RULE6]
          esh = 1'b0;
        end else if (RX_FV[p] != q_l.fv[p]) begin
          ev = 1'b1;
          // Channel bits from the identifier register, sync type below
          edi = raw_di(pc[p]);
          edi[5:0] = RX_FV[p] ? DT_FS : DT_FE; // [RULE4]
        end
      end
      // A header meeting a full slot is dropped
      if (ev && !d_l.pend[p]) begin
        d_l.pend[p] = 1'b1;
        d_l.pdi[p] = edi; // [RULE1]
        d_l.pwc[p] = ewc;
        d_l.psh[p] = esh;
      end
    end
    if (lnk_rst) begin
      d_l = '0;
    end
  end

  // Link domain state
  always_ff @(posedge LINK_CLK) begin
    q_l <= d_l;
  end

  assign SDA_OUT = q_m.sda_o;
  assign SDA_OE_N = q_m.oe_n;
  assign LANE_RATE_MBPS = q_m.lane;
  assign PLL_RATE_SEL = q_m.pll;
  assign HS_TIMING = q_m.hs_out;
  assign TIMING_OVR = q_m.ovr;
  assign TX_VLD = q_l.vld;
  assign TX_DI = q_l.di;
  assign TX_WC = q_l.wc;
  assign TX_SHORT = q_l.sh;

  // Checks on the register domain
  a_rate_no_rsvd: assert property ( // [RULE12]
    @(posedge MCLK) disable iff (SYS_RST)
    q_m.rate[1:0] != RATE_RSVD) else $error("Reserved rate stored");
  a_lane_scale: assert property ( // [RULE13]
    @(posedge MCLK) disable iff (SYS_RST)
    q_m.rate[1:0] == RATE_1600 |=>
    LANE_RATE_MBPS == {1'h0, $past(q_m.ref2), 6'h00})
    else $error("Lane rate not scaled");
  a_auto_timing: assert property ( // [RULE14]
    @(posedge MCLK) disable iff (SYS_RST)
    (q_m.rate == RATE_RST) |=> HS_TIMING == HS_AUTO_1600)
    else $error("Automatic timing missing");
  a_slow_timing: assert property ( // [RULE17]
    @(posedge MCLK) disable iff (SYS_RST)
    q_m.rate[1:0] == RATE_400 |=> HS_TIMING == $past(q_m.hs))
    else $error("Slow rate timing not from host");
  // Checks on the link domain
  a_dt_pass: assert property ( // [RULE2] [RULE10]
    @(posedge LINK_CLK) disable iff (lnk_rst)
    pc[0].mode == MODE_CSI2 && RX_PKT_VLD[0] && !q_l.pend[0] |=>
    q_l.pdi[0] == {remap_vc($past(pc[0].remap), $past(RX_VC[0])),
                   $past(RX_DT[0])}) else $error("Identifier wrong");
  a_short_type: assert property ( // [RULE20]
    @(posedge LINK_CLK) disable iff (lnk_rst)
    pc[0].mode == MODE_CSI2 && RX_PKT_VLD[0] && !q_l.pend[0] &&
    RX_DT[0] <= DT_SHORT_MAX |=> q_l.psh[0])
    else $error("Short type not flagged");
  // Raw traffic runs on port 1, so the raw identifier is watched there
  a_raw_type: assert property ( // [RULE7] [RULE8]
    @(posedge LINK_CLK) disable iff (lnk_rst)
    pc[1].mode == MODE_RAW12 && !RX_LV[1] && q_l.lv[1] &&
    !q_l.pend[1] |=> q_l.pdi[1] == $past(pc[1].raw12) && !q_l.psh[1])
    else $error("Raw identifier wrong");
  a_fs_on_fv: assert property ( // [RULE4]
    @(posedge LINK_CLK) disable iff (lnk_rst)
    pc[1].mode != MODE_CSI2 && RX_FV[1] && !q_l.fv[1] &&
    RX_LV[1] == q_l.lv[1] && !q_l.pend[1] |=> q_l.pdi[1][5:0] == DT_FS)
    else $error("Frame start missing");
  a_grant_out: assert property ( // [RULE11]
    @(posedge LINK_CLK) disable iff (lnk_rst)
    q_l.pend == 2'b01 |=> TX_VLD && TX_DI == $past(q_l.pdi[0]))
    else $error("Waiting header not sent");
  c_csi_out: cover property (@(posedge LINK_CLK) TX_VLD && !TX_SHORT);
  c_both_pend: cover property (@(posedge LINK_CLK) q_l.pend == 2'b11);
  c_raw_line: cover property (@(posedge LINK_CLK)
    pc[1].mode == MODE_RAW10 && !RX_LV[1] && q_l.lv[1]);
  c_rate_400: cover property (@(posedge MCLK) q_m.rate[1:0] == RATE_400);
endmodule // ccmr_top

// [design/ccmr_pkg.sv]
// Package with register map, reset values and types of the channel mapper
package ccmr_pkg;
  // Register offsets
  localparam logic [7:0] REG_LANE_STS = 8'h1E;
  localparam logic [7:0] REG_RATE = 8'h1F;
  localparam logic [7:0] REG_PORT_SEL = 8'h4C;
  localparam logic [7:0] REG_PORT_MODE = 8'h6D;
  localparam logic [7:0] REG_RAW10 = 8'h70;
  localparam logic [7:0] REG_RAW12 = 8'h71;
  localparam logic [7:0] REG_REMAP = 8'h72;
  localparam logic [7:0] REG_HS_TIMING = 8'hB2;
  // Rate field codes and field positions
  localparam logic [1:0] RATE_1600 = 2'h0;
  localparam logic [1:0] RATE_RSVD = 2'h1;
  localparam logic [1:0] RATE_800 = 2'h2;
  localparam logic [1:0] RATE_400 = 2'h3;
  localparam int RATE_OVR_BIT = 7;
  // Automatic lane timing values
  localparam logic [7:0] HS_AUTO_1600 = 8'h0C;
  localparam logic [7:0] HS_AUTO_800 = 8'h06;
  // Reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] HS_RST = 8'h00;
  localparam logic [7:0] RAW10_RST = 8'h2B;
  localparam logic [7:0] RAW12_RST = 8'h2C;
  localparam logic [7:0] REMAP_RST = 8'hE4;
  // Data type codes
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [5:0] DT_SHORT_MAX = 6'h0F;
  // Per-port input mode
  typedef enum logic [1:0] {
    MODE_CSI2 = 2'h0,
    MODE_RAW10 = 2'h1,
    MODE_RAW12 = 2'h2,
    MODE_RAW8 = 2'h3
  } ccmr_mode_type;
  // Per-port configuration
  typedef struct packed {
    ccmr_mode_type mode;
    logic [7:0] raw10;
    logic [7:0] raw12;
    logic [7:0] remap;
  } ccmr_pcfg_type;
  typedef ccmr_pcfg_type [1:0] ccmr_cfg_type;
  localparam ccmr_pcfg_type PCFG_RST = '{MODE_CSI2, RAW10_RST, RAW12_RST,
                                         REMAP_RST};
endpackage

// [design/ccmr_cfg_if.sv]
// Interface carrying the configuration word across clock domains
`timescale 1ns/1ps
interface ccmr_cfg_if import ccmr_pkg::*; ();
  ccmr_cfg_type data; // Held stable while a request is open
  logic req_t; // Toggles once per new word
  logic ack_t; // Echo of req_t once captured
  modport src(output data, output req_t, input ack_t);
  modport dst(input data, input req_t, output ack_t);
endinterface

// [design/ccmr_cfg_sync.sv]
// Link-side capture of the configuration word and reset synchroniser
`timescale 1ns/1ps
module ccmr_cfg_sync import ccmr_pkg::*; (
  input wire logic link_clk,
  input wire logic sys_rst,
  ccmr_cfg_if.dst cfg_if,
  output ccmr_cfg_type cfg,
  output logic link_rst
);
  // Whole state of the module
  typedef struct packed {
    logic r1; // Reset sync stage one
    logic r2; // Reset sync stage two
    logic q1; // Request sync stage one
    logic q2; // Request sync stage two
    logic q3; // Last seen request level
    logic ack; // Acknowledge toggle
    ccmr_cfg_type cfg; // Captured word
  } ccmr_sync_type;
  ccmr_sync_type q;
  ccmr_sync_type d;

  // Next state: capture on each request toggle
  always_comb begin
    d = q;
    d.r1 = sys_rst;
    d.r2 = q.r1;
    d.q1 = cfg_if.req_t;
    d.q2 = q.q1;
    d.q3 = q.q2;
    if (q.q2 != q.q3) begin
      d.cfg = cfg_if.data;
      d.ack = q.q2;
    end
    if (q.r2) begin
      d.q1 = 1'b0;
      d.q2 = 1'b0;
      d.q3 = 1'b0;
      d.ack = 1'b0;
      d.cfg = {2{PCFG_RST}};
    end
  end

  // State register
  always_ff @(posedge link_clk) begin
    q <= d;
  end

  assign cfg = q.cfg;
  assign link_rst = q.r2;
  assign cfg_if.ack_t = q.ack;
endmodule // ccmr_cfg_sync

// [dv/ccmr_sink.sv]
// Downstream receiver model that collects the headers sent by the mapper
`timescale 1ns/1ps
module ccmr_sink (
  input wire logic link_clk,
  input wire logic tx_vld,
  input wire logic [7:0] tx_di,
  input wire logic [15:0] tx_wc,
  input wire logic tx_short
);
  // Headers seen, oldest first: {short, identifier, word count}
  logic [24:0] got[$];
  // Take each header in the one cycle its strobe stands
  always @(posedge link_clk) begin
    if (tx_vld === 1'b1) begin
      // Streams are told apart by the channel bits alone
      got.push_back({tx_short, tx_di, tx_wc});
    end
  end
endmodule // ccmr_sink

// [dv/test_ccmr_top.sv]
// Self-checking bench for the mapper: registers, lane rate and link traffic
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module test_ccmr_top import ccmr_pkg::*; ;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1; // Bench side of the open-drain data line
  logic [4:0] ref_mhz = 5'h19;
  logic [1:0] pkt_vld = 2'h0;
  logic [1:0][1:0] rx_vc = '0;
  logic [1:0][5:0] rx_dt = '0;
  logic [1:0][15:0] rx_wc = '0;
  logic [1:0] fv = 2'h0;
  logic [1:0] lv = 2'h0;
  logic [1:0] pix = 2'h0;
  logic sda_out, sda_oe_n, tx_vld, tx_short, t_ovr;
  logic [7:0] tx_di, hs_t;
  logic [15:0] tx_wc;
  logic [11:0] lane;
  logic [1:0] pll_sel;
  int err_total = 0;
  int compares = 0;
  // Lookup tables for the loops below
  logic [5:0] dt_tab[4] = '{6'h0F, 6'h10, 6'h2B, 6'h00};
  logic [7:0] di_tab[4] = '{8'h00, 8'h6A, 8'hAC, 8'h6A};
  logic [15:0] wc_tab[4] = '{16'h0000, 16'h000A, 16'h000C, 16'h0008};
  logic [4:0] ref_tab[3] = '{5'h19, 5'h1A, 5'h17};
  logic [11:0] mb_tab[3] = '{12'h640, 12'h680, 12'h5C0};
  // Wired-AND with pull-up: either party may pull low
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  // Register clock 50 ns
  always #25 mclk = ~mclk;
  // Link clock 12 ns with an odd phase offset
  initial begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end
  ccmr_top dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .LINK_CLK(link_clk),
    .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
    .REF_MHZ(ref_mhz), .RX_PKT_VLD(pkt_vld), .RX_VC(rx_vc), .RX_DT(rx_dt),
    .RX_WC(rx_wc), .RX_FV(fv), .RX_LV(lv), .RX_PIX_VLD(pix),
    .TX_VLD(tx_vld), .TX_DI(tx_di), .TX_WC(tx_wc), .TX_SHORT(tx_short),
    .LANE_RATE_MBPS(lane), .PLL_RATE_SEL(pll_sel), .HS_TIMING(hs_t),
    .TIMING_OVR(t_ovr));
  ccmr_sink sink_u (.link_clk(link_clk), .tx_vld(tx_vld), .tx_di(tx_di),
    .tx_wc(tx_wc), .tx_short(tx_short));
  // Prints counts and verdict, then ends the run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Half an SCL period, well above the four-cycle minimum
  task automatic half();
    repeat (6) @(negedge mclk);
  endtask
  // One bit; data moves only while SCL is low
  task automatic bitx(input logic b, output logic r);
    repeat (2) @(negedge mclk);
    sda_m = b;
    half();
    scl = 1'b1;
    half();
    r = sda_w;
    scl = 1'b0;
  endtask
  // One byte MSB first plus the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic rd,
                      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(1'b1, r); // Released: slave acks, or master nacks a read
    if (!rd) `CHK("ack", 1'b0, r)
  endtask
  task automatic start();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(negedge mclk);
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask
  // Register write, then time for the link-side copy to settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer(8'h7A, 1'b0, q);
    xfer(a, 1'b0, q);
    xfer(d, 1'b0, q);
    stop();
    repeat (20) @(negedge mclk);
  endtask
  // Register read with repeated start, compared to the expected byte
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    start();
    xfer(8'h7A, 1'b0, q);
    xfer(a, 1'b0, q);
    repeat (2) @(negedge mclk);
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    start();
    xfer(8'h7B, 1'b0, q);
    xfer(8'hFF, 1'b1, q);
    stop();
    `CHK("register", e, q)
  endtask
  // One-cycle header on the masked ports; lines scrambled after release
  task automatic pkt(input logic [1:0] m, input logic [1:0] vc,
                     input logic [5:0] dt, input logic [15:0] wc);
    @(negedge link_clk);
    rx_vc = {vc, vc};
    rx_dt = {dt, dt};
    rx_wc = {wc, wc};
    pkt_vld = m;
    @(negedge link_clk);
    pkt_vld = 2'h0;
    rx_vc = ~rx_vc;
    rx_dt = ~rx_dt;
    rx_wc = ~rx_wc;
    repeat (4) @(negedge link_clk);
  endtask
  // Raw frame on port 1 with discrete frame and line levels
  task automatic raw_run();
    @(negedge link_clk);
    fv[1] = 1'b1;
    repeat (5) @(negedge link_clk);
    lv[1] = 1'b1;
    repeat (8) begin
      @(negedge link_clk);
      pix[1] = 1'b1;
    end
    @(negedge link_clk);
    pix[1] = 1'b0;
    lv[1] = 1'b0;
    repeat (5) @(negedge link_clk);
    fv[1] = 1'b0;
    repeat (5) @(negedge link_clk);
  endtask
  // Oldest header from the receiver, unknown if none comes in time
  task automatic pop(output logic [24:0] h);
    int n;
    n = 0;
    while (sink_u.got.size() == 0 && n < 60) begin
      @(negedge link_clk);
      n++;
    end
    if (sink_u.got.size() == 0) begin
      h = 'x;
    end else begin
      h = sink_u.got.pop_front();
    end
  endtask
  // Main sequence
  initial begin
    logic [24:0] h, g;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
    // Reset values and an unmapped read
    chk_rd(REG_RATE, RATE_RST);
    chk_rd(REG_RAW10, RAW10_RST);
    chk_rd(REG_RAW12, RAW12_RST);
    chk_rd(REG_REMAP, REMAP_RST);
    chk_rd(8'h50, 8'h00);
    `CHK("hs timing", HS_AUTO_1600, hs_t)
    // Lane rate follows the reference at setting 00
    for (int i = 0; i < 3; i++) begin
      ref_mhz = ref_tab[i];
      repeat (8) @(negedge mclk);
      `CHK("lane rate", mb_tab[i], lane)
    end
    // Back to the nominal reference for the rate checks that follow
    ref_mhz = ref_tab[0];
    chk_rd(REG_LANE_STS, 8'h64);
    // Slower rates: automatic timing at 800, host timing at 400
    wr(REG_HS_TIMING, 8'h86);
    wr(REG_RATE, {6'h00, RATE_800});
    `CHK("pll select", RATE_800, pll_sel)
    `CHK("lane rate", 12'h320, lane)
    `CHK("hs timing", HS_AUTO_800, hs_t)
    wr(REG_RATE, {6'h00, RATE_400});
    `CHK("lane rate", 12'h190, lane)
    `CHK("hs timing", 8'h86, hs_t)
    wr(REG_RATE, {6'h00, RATE_RSVD});
    chk_rd(REG_RATE, 8'h03);
    `CHK("pll select", RATE_400, pll_sel)
    // Override at 1600 picks the host value
    wr(REG_RATE, 8'h80);
    `CHK("override", 1'b1, t_ovr)
    `CHK("hs timing", 8'h86, hs_t)
    // Port 0 remap reverses the channels; type untouched
    wr(REG_REMAP, 8'h1B);
    chk_rd(REG_REMAP, 8'h1B);
    for (int v = 0; v < 4; v++) begin
      g[24] = (dt_tab[v] <= DT_SHORT_MAX);
      g[23:16] = {2'(3 - v), dt_tab[v]};
      g[15:0] = g[24] ? 16'h0000 : 16'h0100 + 16'(v);
      pkt(2'b01, 2'(v), dt_tab[v], g[15:0]);
      pop(h);
      `CHK("csi header", g, h)
    end
    // Both ports at once, merged and told apart by channel
    pkt(2'b11, 2'h0, 6'h2B, 16'h0040);
    pop(h);
    pop(g);
    `CHK("port 1 header", 25'h02B0040, (h < g) ? h : g)
    `CHK("port 0 header", 25'h0EB0040, (h < g) ? g : h)
    // Raw modes on port 1: raw10, raw12, raw8
    wr(REG_PORT_SEL, 8'h01);
    wr(REG_RAW10, 8'h6A);
    wr(REG_RAW12, 8'hAC);
    for (int m = 1; m < 4; m++) begin
      wr(REG_PORT_MODE, {6'h00, 2'(m)});
      raw_run();
      pop(h);
      `CHK("frame open", {1'b1, di_tab[m][7:6], DT_FS, 16'h0000}, h)
      pop(h);
      `CHK("line", {1'b0, di_tab[m], wc_tab[m]}, h)
      pop(h);
      `CHK("frame end", {1'b1, di_tab[m][7:6], DT_FE, 16'h0000}, h)
    end
    wrap_up();
  end
  // Watchdog: the sequence needs about half a millisecond, 1 ms is a hang
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end
endmodule // test_ccmr_top
